// ### hw/sram_ctrl_pkg.sv
`default_nettype none
package sram_ctrl_pkg;
  localparam int LANE_W      = 9;
  localparam int LANES_WIDE  = 4;
  localparam int ADDR_W_WIDE = 19;
  localparam int BURST_W     = 2;
  localparam int FIFO_DEPTH  = 16;

  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

  typedef enum logic [1:0] {
    OP_DESEL = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_type;

  // Control pins sampled on the clock, including the output-enable and sleep gates
  typedef struct packed {
    logic clk_en_n;
    logic advance_load;
    logic chip_sel_primary_n;
    logic chip_sel_secondary;
    logic chip_sel_tertiary_n;
    logic write_en_n;
    logic out_en_n;
    logic sleep_request;
    logic burst_order_select;
  } ctrl_pins_type;

  localparam ctrl_pins_type CTRL_IDLE = '{clk_en_n: 1'b1, advance_load: 1'b1,
                                          chip_sel_primary_n: 1'b1,
                                          chip_sel_secondary: 1'b0,
                                          chip_sel_tertiary_n: 1'b1,
                                          write_en_n: 1'b1, out_en_n: 1'b1,
                                          sleep_request: 1'b0,
                                          burst_order_select: 1'b0};
endpackage : sram_ctrl_pkg
`default_nettype wire

// ### hw/sram_ctrl.sv
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0]   CNT_FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    wp_nxt;
  logic [PW-1:0]    rp_r;
  logic [PW-1:0]    rp_nxt;
  logic [PW:0]      cnt_r;
  logic [PW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != CNT_FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == PTR_LAST) ? '0 : wp_r + PW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == PTR_LAST) ? '0 : rp_r + PW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : sync_fifo

module sram_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter int ADDR_W = sram_ctrl_pkg::ADDR_W_WIDE,
  parameter int LANES  = sram_ctrl_pkg::LANES_WIDE
) (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire sram_ctrl_pkg::ctrl_pins_type          ctrl_pins,
  input  wire logic [ADDR_W-1:0]                     addr_pins,
  input  wire logic [LANES-1:0]                      byte_lane_write_n,
  input  wire logic [LANES*sram_ctrl_pkg::LANE_W-1:0] dq_in,
  output logic      [LANES*sram_ctrl_pkg::LANE_W-1:0] dq_out,
  output logic                                       dq_oe_n,
  output logic                                       powered_down
);
  import sram_ctrl_pkg::*;

  localparam int DW = LANES * LANE_W;
  localparam int QW = ADDR_W + LANES + DW;

  // Two-stage input synchronisers
  ctrl_pins_type     c_m_r;
  ctrl_pins_type     c_s_r;
  logic [ADDR_W-1:0] a_m_r;
  logic [ADDR_W-1:0] a_s_r;
  logic [LANES-1:0]  b_m_r;
  logic [LANES-1:0]  b_s_r;
  logic [DW-1:0]     d_m_r;
  logic [DW-1:0]     d_s_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c_m_r <= CTRL_IDLE;
      c_s_r <= CTRL_IDLE;
      a_m_r <= '0;
      a_s_r <= '0;
      b_m_r <= '1;
      b_s_r <= '1;
      d_m_r <= '0;
      d_s_r <= '0;
    end else begin
      c_m_r <= ctrl_pins;
      c_s_r <= c_m_r;
      a_m_r <= addr_pins;
      a_s_r <= a_m_r;
      b_m_r <= byte_lane_write_n;
      b_s_r <= b_m_r;
      d_m_r <= dq_in;
      d_s_r <= d_m_r;
    end
  end

  logic [DW-1:0] array_mem [2**ADDR_W];

  logic          wq_in_ready;
  logic          wq_push;
  logic [QW-1:0] wq_in_data;
  logic          wq_out_valid;
  logic [QW-1:0] wq_out_data;

  // Command state
  op_type             op_r;
  op_type             op_nxt;
  logic [ADDR_W-1:0]  base_r;
  logic [ADDR_W-1:0]  base_nxt;
  logic [BURST_W-1:0] cnt_r;
  logic [BURST_W-1:0] cnt_nxt;
  logic               hold;
  logic               sel;
  logic               load;
  logic [BURST_W-1:0] low_bits;
  logic [ADDR_W-1:0]  beat_addr;
  logic               beat_rd;
  logic               beat_wr;
  logic [LANES-1:0]   beat_lanes;

  assign hold = c_s_r.clk_en_n || c_s_r.sleep_request || !wq_in_ready;
  assign sel  = !c_s_r.chip_sel_primary_n && c_s_r.chip_sel_secondary
                && !c_s_r.chip_sel_tertiary_n;
  assign load = !c_s_r.advance_load;

  always_comb begin
    op_nxt   = op_r;
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    if (!hold) begin
      if (load) begin
        cnt_nxt  = BURST_START;
        base_nxt = a_s_r;
        if (!sel) begin
          op_nxt = OP_DESEL;
        end else if (c_s_r.write_en_n) begin
          op_nxt = OP_READ;
        end else begin
          op_nxt = OP_WRITE;
        end
      end else begin
        cnt_nxt = cnt_r + BURST_STEP;
      end
    end
  end

  // Burst address order
  always_comb begin
    if (c_s_r.burst_order_select) begin
      low_bits = base_nxt[BURST_W-1:0] ^ cnt_nxt;
    end else begin
      low_bits = base_nxt[BURST_W-1:0] + cnt_nxt;
    end
    beat_addr  = {base_nxt[ADDR_W-1:BURST_W], low_bits};
    beat_rd    = !hold && (op_nxt == OP_READ);
    beat_wr    = !hold && (op_nxt == OP_WRITE);
    beat_lanes = ~b_s_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_r   <= OP_DESEL;
      base_r <= '0;
      cnt_r  <= BURST_START;
    end else begin
      op_r   <= op_nxt;
      base_r <= base_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // Late write pipeline: address edge, one edge, data edge
  logic              w1_v_r;
  logic              w1_v_nxt;
  logic [ADDR_W-1:0] w1_a_r;
  logic [ADDR_W-1:0] w1_a_nxt;
  logic [LANES-1:0]  w1_l_r;
  logic [LANES-1:0]  w1_l_nxt;
  logic              w2_v_r;
  logic              w2_v_nxt;
  logic [ADDR_W-1:0] w2_a_r;
  logic [ADDR_W-1:0] w2_a_nxt;
  logic [LANES-1:0]  w2_l_r;
  logic [LANES-1:0]  w2_l_nxt;

  always_comb begin
    w1_v_nxt = w1_v_r;
    w1_a_nxt = w1_a_r;
    w1_l_nxt = w1_l_r;
    w2_v_nxt = w2_v_r;
    w2_a_nxt = w2_a_r;
    w2_l_nxt = w2_l_r;
    if (!hold) begin
      w1_v_nxt = beat_wr;
      w1_a_nxt = beat_addr;
      w1_l_nxt = beat_lanes;
      w2_v_nxt = w1_v_r;
      w2_a_nxt = w1_a_r;
      w2_l_nxt = w1_l_r;
    end
    wq_push    = !hold && w2_v_r && (w2_l_r != '0);
    wq_in_data = {w2_a_r, w2_l_r, d_s_r};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w1_v_r <= 1'b0;
      w1_a_r <= '0;
      w1_l_r <= '0;
      w2_v_r <= 1'b0;
      w2_a_r <= '0;
      w2_l_r <= '0;
    end else begin
      w1_v_r <= w1_v_nxt;
      w1_a_r <= w1_a_nxt;
      w1_l_r <= w1_l_nxt;
      w2_v_r <= w2_v_nxt;
      w2_a_r <= w2_a_nxt;
      w2_l_r <= w2_l_nxt;
    end
  end

  sync_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_write_queue (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (wq_push),
    .in_ready  (wq_in_ready),
    .in_data   (wq_in_data),
    .out_valid (wq_out_valid),
    .out_ready (!c_s_r.sleep_request),
    .out_data  (wq_out_data)
  );

  // Array write drains the queue, stalled while asleep
  always_ff @(posedge clk) begin
    if (wq_out_valid && !c_s_r.sleep_request) begin
      for (int i = 0; i < LANES; i++) begin
        if (wq_out_data[DW+i]) begin
          array_mem[wq_out_data[QW-1 -: ADDR_W]][i*LANE_W +: LANE_W] <=
            wq_out_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Read pipeline and output gating
  logic              r1_v_r;
  logic              r1_v_nxt;
  logic [ADDR_W-1:0] r1_a_r;
  logic [ADDR_W-1:0] r1_a_nxt;
  logic              ro_v_r;
  logic              ro_v_nxt;
  logic [DW-1:0]     dq_out_r;
  logic [DW-1:0]     dq_out_nxt;
  logic              dq_oe_n_r;
  logic              dq_oe_n_nxt;
  logic              pd_r;
  logic              pd_nxt;

  always_comb begin
    r1_v_nxt   = r1_v_r;
    r1_a_nxt   = r1_a_r;
    ro_v_nxt   = ro_v_r;
    dq_out_nxt = dq_out_r;
    if (!hold) begin
      r1_v_nxt = beat_rd;
      r1_a_nxt = beat_addr;
      ro_v_nxt = r1_v_r;
      if (r1_v_r) begin
        dq_out_nxt = array_mem[r1_a_r];
      end
    end
    dq_oe_n_nxt = !(ro_v_nxt && !c_s_r.out_en_n && !c_s_r.sleep_request);
    pd_nxt      = c_s_r.sleep_request;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r1_v_r    <= 1'b0;
      r1_a_r    <= '0;
      ro_v_r    <= 1'b0;
      dq_out_r  <= '0;
      dq_oe_n_r <= 1'b1;
      pd_r      <= 1'b0;
    end else begin
      r1_v_r    <= r1_v_nxt;
      r1_a_r    <= r1_a_nxt;
      ro_v_r    <= ro_v_nxt;
      dq_out_r  <= dq_out_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      pd_r      <= pd_nxt;
    end
  end

  assign dq_out       = dq_out_r;
  assign dq_oe_n      = dq_oe_n_r;
  assign powered_down = pd_r;

  a_ignore_hold: assert property (@(posedge clk) disable iff (!rstn)
    hold |=> $stable(op_r) && $stable(cnt_r) && $stable(base_r))
    else $error("state changed on an ignored edge");

  a_load_read: assert property (@(posedge clk) disable iff (!rstn)
    !hold && load && sel && c_s_r.write_en_n |=> op_r == OP_READ
      && base_r == $past(a_s_r) && cnt_r == BURST_START)
    else $error("read load not taken");

  a_load_write: assert property (@(posedge clk) disable iff (!rstn)
    !hold && load && sel && !c_s_r.write_en_n |=> op_r == OP_WRITE)
    else $error("write load not taken");

  a_load_desel: assert property (@(posedge clk) disable iff (!rstn)
    !hold && load && !sel |=> op_r == OP_DESEL && !r1_v_r && !w1_v_r)
    else $error("deselect not taken");

  a_burst_step: assert property (@(posedge clk) disable iff (!rstn)
    !hold && !load |=> op_r == $past(op_r) && cnt_r == 2'($past(cnt_r) + BURST_STEP))
    else $error("burst did not advance");

  a_read_latency: assert property (@(posedge clk) disable iff (!rstn)
    beat_rd ##1 !hold |=> ro_v_r)
    else $error("read data not ready at second edge");

  a_write_delay: assert property (@(posedge clk) disable iff (!rstn)
    (beat_wr && beat_lanes != '0) ##1 !hold ##1 !hold |-> wq_push)
    else $error("write data not taken two edges later");

  a_write_abort: assert property (@(posedge clk) disable iff (!rstn)
    (beat_wr && beat_lanes == '0) ##1 !hold ##1 !hold |-> !wq_push)
    else $error("aborted write reached the queue");

  a_oe_gate: assert property (@(posedge clk) disable iff (!rstn)
    !dq_oe_n_r |-> $past(!c_s_r.out_en_n && !c_s_r.sleep_request && ro_v_nxt))
    else $error("pins driven without enable");

  a_sleep_hiz: assert property (@(posedge clk) disable iff (!rstn)
    c_s_r.sleep_request |=> dq_oe_n_r && powered_down)
    else $error("pins driven in sleep");

  a_desel_hiz: assert property (@(posedge clk) disable iff (!rstn)
    (!hold && op_nxt == OP_DESEL) [*2] |=> dq_oe_n_r)
    else $error("pins driven while deselected");
endmodule : sram_ctrl
`default_nettype wire

// ### verification/sram_master_model.sv
`default_nettype none
module sram_master_model
  import sram_ctrl_pkg::*;
#(
  parameter int AW = 6,
  parameter int NL = 4
) (
  input  wire logic                          clk,
  output sram_ctrl_pkg::ctrl_pins_type       pins,
  output logic [AW-1:0]                      addr,
  output logic [NL-1:0]                      strb_n,
  output logic [NL*sram_ctrl_pkg::LANE_W-1:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NL*LANE_W-1:0] s1;
  logic [NL*LANE_W-1:0] s2;
  initial begin
    pins = CTRL_IDLE;
    addr = '0;
    strb_n = '1;
    wdata = '0;
    s1 = '0;
    s2 = '0;
  end
  // One cycle of pins; write data trails its beat by two active edges
  task automatic step(input ctrl_pins_type p, input logic [AW-1:0] a,
                      input logic [NL-1:0] s, input logic [NL*LANE_W-1:0] d);
    @(posedge clk);
    pins <= p;
    addr <= a;
    strb_n <= s;
    if (!p.clk_en_n) begin
      wdata <= s2;
      s2 <= s1;
      s1 <= d;
    end else begin
      wdata <= ~wdata;
    end
  endtask : step
endmodule : sram_master_model
`default_nettype wire

// ### verification/sram_ctrl_test.sv
`default_nettype none
module sram_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ctrl_pkg::*;
  localparam int AW = 6;
  localparam int NL = 4;
  localparam int W  = NL * LANE_W;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
  logic          clk = 1'b0;
  logic          rstn;
  ctrl_pins_type pins;
  logic [AW-1:0] addr;
  logic [NL-1:0] strb_n;
  logic [W-1:0]  wdata, dq_out, prev_out, e;
  logic [W-1:0]  mem [0:63];
  logic [W-1:0]  exp_q [$];
  logic          dq_oe_n, powered_down, prev_oe, zz, oen;
  int            n_errors, checks, cyc;
  logic [2*LANE_W-1:0] dq_out_nw;
  logic                dq_oe_n_nw;

  always #2 clk = ~clk;

  sram_master_model #(.AW(AW), .NL(NL)) M (
    .clk    (clk),
    .pins   (pins),
    .addr   (addr),
    .strb_n (strb_n),
    .wdata  (wdata)
  );
  sram_ctrl #(.ADDR_W(AW), .LANES(NL)) DUT (
    .clk               (clk),
    .rstn              (rstn),
    .ctrl_pins         (pins),
    .addr_pins         (addr),
    .byte_lane_write_n (strb_n),
    .dq_in             (wdata),
    .dq_out            (dq_out),
    .dq_oe_n           (dq_oe_n),
    .powered_down      (powered_down)
  );
  // Narrow organisation on the low two lanes of the same stimulus
  sram_ctrl #(.ADDR_W(AW), .LANES(2)) narrow_dut (
    .clk               (clk),
    .rstn              (rstn),
    .ctrl_pins         (pins),
    .addr_pins         (addr),
    .byte_lane_write_n (strb_n[1:0]),
    .dq_in             (wdata[2*LANE_W-1:0]),
    .dq_out            (dq_out_nw),
    .dq_oe_n           (dq_oe_n_nw),
    .powered_down      ()
  );

  function automatic logic [AW-1:0] baddr(input logic [AW-1:0] b, input int n,
                                          input logic il);
    baddr = b;
    baddr[1:0] = il ? b[1:0] ^ 2'(n) : b[1:0] + 2'(n);
  endfunction : baddr

  task automatic idle(input int k);
    ctrl_pins_type p;
    p = CTRL_IDLE;
    p.clk_en_n = 1'b0;
    p.advance_load = 1'b0;
    repeat (k) begin
      p.out_en_n = oen;
      p.sleep_request = zz;
      M.step(p, '0, '1, W'($urandom()));
    end
  endtask : idle

  task automatic burst(input op_type op, input logic [AW-1:0] b, input logic il,
                       input logic full, input int hold);
    ctrl_pins_type p;
    logic [NL-1:0] s;
    logic [W-1:0]  d;
    logic [AW-1:0] a;
    for (int n = 0; n < 4; n++) begin
      if (n == hold) begin
        p = ctrl_pins_type'(9'($urandom()));
        p.clk_en_n = 1'b1;
        p.sleep_request = zz;
        p.out_en_n = oen;
        M.step(p, AW'($urandom()), NL'($urandom()), d);
      end
      p = ctrl_pins_type'(9'($urandom()));
      p.clk_en_n = 1'b0;
      p.advance_load = (n != 0);
      p.out_en_n = oen;
      p.sleep_request = zz;
      p.burst_order_select = il;
      a = baddr(b, n, il);
      s = full ? '0 : (n == 3 ? '1 : NL'($urandom()));
      d = W'({$urandom(), $urandom()});
      if (n == 0) begin
        p.chip_sel_primary_n = (op == OP_DESEL);
        p.chip_sel_secondary = 1'b1;
        p.chip_sel_tertiary_n = 1'b0;
        p.write_en_n = (op != OP_WRITE);
        if (op == OP_WRITE && &s) s[0] = 1'b0;
      end
      if (op == OP_WRITE && !zz)
        for (int i = 0; i < NL; i++)
          if (!s[i]) mem[a][i*LANE_W+:LANE_W] = d[i*LANE_W+:LANE_W];
      if (op == OP_READ && !oen && !zz) exp_q.push_back(mem[a]);
      M.step(p, n == 0 ? b : AW'($urandom()), s, d);
    end
  endtask : burst

  task automatic conclude;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    if (rstn === 1'b1 && dq_oe_n === 1'b0 && (prev_oe !== 1'b0 || dq_out !== prev_out)) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("BAD dq_out exp none got %h", dq_out);
      end else begin
        e = exp_q.pop_front();
        `CHK("dq_out", e, dq_out)
        `CHK("dq_out_narrow", e[2*LANE_W-1:0], dq_out_nw)
        `CHK("dq_oe_n_narrow", 1'b0, dq_oe_n_nw)
      end
    end
    prev_oe <= dq_oe_n;
    prev_out <= dq_out;
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    rstn = 1'b0;
    zz = 1'b0;
    oen = 1'b0;
    void'($urandom(32'h22b96194));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    idle(2);
    burst(OP_WRITE, 6'h01, 1'b0, 1'b1, 9);
    burst(OP_WRITE, 6'h06, 1'b1, 1'b1, 9);
    burst(OP_WRITE, 6'h05, 1'b0, 1'b0, 2);
    burst(OP_READ, 6'h02, 1'b1, 1'b0, 1);
    idle(4);
    burst(OP_READ, 6'h07, 1'b0, 1'b0, 9);
    burst(OP_WRITE, 6'h08, 1'b0, 1'b1, 9);
    idle(4);
    burst(OP_READ, 6'h0a, 1'b1, 1'b0, 9);
    idle(4);
    oen = 1'b1;
    burst(OP_READ, 6'h03, 1'b0, 1'b0, 9);
    idle(4);
    oen = 1'b0;
    burst(OP_DESEL, 6'h00, 1'b0, 1'b0, 9);
    idle(4);
    zz = 1'b1;
    idle(6);
    #1;
    `CHK("powered_down", 1'b1, powered_down)
    `CHK("dq_oe_n", 1'b1, dq_oe_n)
    burst(OP_WRITE, 6'h00, 1'b0, 1'b1, 9);
    burst(OP_READ, 6'h00, 1'b0, 1'b0, 9);
    zz = 1'b0;
    idle(4);
    #1;
    `CHK("powered_down", 1'b0, powered_down)
    burst(OP_READ, 6'h00, 1'b0, 1'b0, 9);
    idle(8);
    `CHK("queue", 0, exp_q.size())
    conclude();
  end
endmodule : sram_ctrl_test
`default_nettype wire
